/* File: core/cmt_regs.svh */
// Register offsets, field positions, reset values and counts of the CAN mode/timing block
`ifndef CMT_REGS_SVH
`define CMT_REGS_SVH
// Byte offsets of the APB registers, and paddr[7:6] codes of the slot register regions
`define CMT_OFS_CTRL    8'h00
`define CMT_OFS_STAT    8'h04
`define CMT_OFS_BCFG    8'h08
`define CMT_OFS_CSEL    8'h0C
`define CMT_OFS_IEN     8'h10
`define CMT_OFS_IDF     8'h14
`define CMT_OFS_REC     8'h18
`define CMT_OFS_TEC     8'h1C
`define CMT_OFS_TSR     8'h20
`define CMT_OFS_GMR     8'h24
`define CMT_OFS_LMA     8'h28
`define CMT_OFS_LMB     8'h2C
`define CMT_OFS_AFS     8'h30
`define CMT_REGION_SCTL 2'h1
`define CMT_REGION_SID  2'h2
// Control register bits
`define CMT_CTL_RESET   0
`define CMT_CTL_SLEEP   1
`define CMT_CTL_LOOP    2
`define CMT_CTL_FIFO    3
`define CMT_CTL_RETBO   4
`define CMT_CTL_TSPRE   5
// Status register bits
`define CMT_ST_TXSUCC   4
`define CMT_ST_RXSUCC   5
`define CMT_ST_TXSTATE  6
`define CMT_ST_RXSTATE  7
`define CMT_ST_RESET    8
`define CMT_ST_LOOP     9
`define CMT_ST_FIFO     11
`define CMT_ST_PASSIVE  13
`define CMT_ST_BUSOFF   14
// Slot control bits
`define CMT_SC_NEWDATA  0
`define CMT_SC_MSGLOST  4
`define CMT_SC_RXREQ    6
`define CMT_SC_TXREQ    7
// Bit configuration fields, each holding length minus one
`define CMT_BC_BRP      0
`define CMT_BC_PROP     4
`define CMT_BC_PS1      8
`define CMT_BC_PS2      12
`define CMT_BC_SJW      16
// Reset values and counts
`define CMT_BCFG_RST    18'h0_2220
`define CMT_STD_MASK    29'h1FFC_0000
`define CMT_CSEL_MAX    3'h4
`define CMT_TEC_INC     9'h008
`define CMT_ERR_PASSIVE 9'h080
`define CMT_ERR_BUSOFF  9'h100
`endif

/* File: core/cmt_pkg.sv */
// Types of the CAN mode/timing block
`default_nettype none
package cmt_pkg;
   typedef enum logic [1:0] {MODE_RESET, MODE_OP, MODE_SLEEP} cmt_mode_t;
   typedef enum logic [1:0] {OPS_IDLE, OPS_RX, OPS_TX} cmt_opst_t;
   typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PS1, SEG_PS2} cmt_seg_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } cmt_apb_req_t;
   typedef struct packed {
      logic        valid;
      logic        ext;
      logic        own;
      logic [28:0] id;
   } cmt_rx_frame_t;
   typedef struct packed {
      logic       tx_err;
      logic       rx_err;
      logic       tx_ok;
      logic       rx_ok;
      logic [3:0] tx_slot;
   } cmt_err_evt_t;
   typedef struct packed {
      logic       valid;
      logic [3:0] slot;
   } cmt_accept_t;
   typedef struct packed {
      cmt_mode_t        mode;
      cmt_opst_t        opst;
      logic             rst_req;
      logic             sleep;
      logic             loop;
      logic             fifo;
      logic [1:0]       ts_pre;
      logic [17:0]      bcfg;
      logic [2:0]       csel;
      logic [15:0]      ien;
      logic [15:0]      idf;
      logic [7:0]       rec;
      logic [8:0]       tec;
      logic             busoff;
      logic [15:0]      ts;
      logic [2:0]       ts_div;
      logic [28:0]      gmr;
      logic [28:0]      lma;
      logic [28:0]      lmb;
      logic [10:0]      afs;
      logic [15:0][7:0] sctl;
      logic [15:0][28:0] sid;
      logic [3:0]       last_slot;
      logic             rx_succ;
      logic             tx_succ;
      logic             fifo_next;
      logic [31:0]      prdata;
      logic             pslverr;
      logic [9:0]       psc;
      logic             tq;
      cmt_seg_t         seg;
      logic [3:0]       seg_cnt;
      logic [3:0]       ps1_ext;
      logic             edge_pend;
      logic             sample;
      logic             bit_tick;
      logic             rx_s1;
      logic             rx_s2;
      logic             rx_prev;
      cmt_accept_t      acc;
      logic             reinit;
   } cmt_state_t;
endpackage : cmt_pkg
`default_nettype wire

/* File: core/cmt_ctrl.sv */
// CAN channel mode control, bit timing, acceptance filter and time stamp with APB registers
`timescale 1ns/10ps
`default_nettype none
`include "cmt_regs.svh"
module cmt_ctrl (
   input  wire logic                   i_clk,
   input  wire logic                   i_sys_rst,
   input  wire cmt_pkg::cmt_apb_req_t  i_apb,
   output logic [31:0]                 o_prdata,
   output logic                        o_pready,
   output logic                        o_pslverr,
   input  wire logic                   i_can_rx,
   input  wire logic                   i_tx_busy,
   input  wire logic                   i_rx_busy,
   input  wire cmt_pkg::cmt_rx_frame_t i_rx_frame,
   input  wire cmt_pkg::cmt_err_evt_t  i_err_evt,
   output cmt_pkg::cmt_accept_t        o_accept,
   output logic                        o_clk_gate_en,
   output logic                        o_tx_enable,
   output logic                        o_loopback,
   output logic                        o_engine_reinit,
   output logic                        o_tq_tick,
   output logic                        o_sample_point,
   output logic                        o_bit_tick,
   output logic [15:0]                 o_slot_irq_en
);
   import cmt_pkg::*;

   cmt_state_t  s_reg;
   cmt_state_t  s_next;
   logic [15:0] match;

   // ****************************************************************
   // Per-slot acceptance compare
   // ****************************************************************
   genvar gj;
   generate
      for (gj = 0; gj < 16; gj++) begin : g_slot
         logic [28:0] mask;
         logic [28:0] diff;
         assign mask = (gj < 14) ? s_reg.gmr : ((gj == 14) ? s_reg.lma : s_reg.lmb);
         assign diff = (i_rx_frame.id ^ s_reg.sid[gj]) & mask
                       & (s_reg.idf[gj] ? 29'h1FFF_FFFF : `CMT_STD_MASK);
         assign match[gj] = s_reg.sctl[gj][`CMT_SC_RXREQ] && !s_reg.sctl[gj][`CMT_SC_TXREQ]
                            && (s_reg.idf[gj] == i_rx_frame.ext) && (diff == 29'h0000_0000);
      end
   endgenerate

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic        op;
      logic        setup;
      logic        wr;
      logic [31:0] rd;
      logic [31:0] wd;
      logic [3:0]  idx;
      logic [2:0]  dsel;
      logic [9:0]  psc_lim;
      logic        tq_now;
      logic [3:0]  prop_len;
      logic [3:0]  ps1_len;
      logic [3:0]  ps2_len;
      logic [3:0]  resync_jump_width;
      logic [3:0]  perr;
      logic        fall;
      logic        hit;
      logic [3:0]  slot;
      logic [2:0]  tsm;
      logic [7:0]  onehot;
      s_next   = s_reg;
      op       = (s_reg.mode == MODE_OP);
      setup    = i_apb.psel && !i_apb.penable;
      wr       = i_apb.psel && i_apb.penable && i_apb.pwrite;
      wd       = i_apb.pwdata;
      idx      = i_apb.paddr[5:2];
      rd       = 32'h0000_0000;
      hit      = 1'b0;
      slot     = 4'h0;
      onehot   = 8'h01 << s_reg.afs[2:0];
      tsm      = 3'((4'h1 << s_reg.ts_pre) - 4'h1);
      s_next.tq        = 1'b0;
      s_next.sample    = 1'b0;
      s_next.bit_tick  = 1'b0;
      s_next.acc.valid = 1'b0;
      s_next.reinit    = 1'b0;
      s_next.rx_s1     = i_can_rx;
      s_next.rx_s2     = s_reg.rx_s1;
      s_next.rx_prev   = s_reg.rx_s2;
      s_next.opst      = i_tx_busy ? OPS_TX : (i_rx_busy ? OPS_RX : OPS_IDLE);

      // Operational mode transitions
      case (s_reg.mode)
         MODE_RESET: begin
            if (s_reg.sleep) begin
               s_next.mode = MODE_SLEEP;
            end else if (!s_reg.rst_req) begin
               s_next.mode = MODE_OP;
            end
         end
         MODE_OP: begin
            if (s_reg.rst_req && !i_tx_busy) begin
               s_next.mode = MODE_RESET;
            end
         end
         MODE_SLEEP: begin
            if (!s_reg.sleep) begin
               s_next.mode = MODE_RESET;
            end
         end
         default: begin
            s_next.mode = MODE_RESET;
         end
      endcase

      // Register read, captured in the setup phase
      if (setup) begin
         s_next.pslverr = (i_apb.paddr[1:0] != 2'h0);
         if (i_apb.paddr[7:6] == `CMT_REGION_SCTL) begin
            rd = {24'h00_0000, s_reg.sctl[idx]};
         end else if (i_apb.paddr[7:6] == `CMT_REGION_SID) begin
            rd = {3'h0, s_reg.sid[idx]};
         end else begin
            case (i_apb.paddr)
               `CMT_OFS_CTRL: begin
                  rd = {25'h000_0000, s_reg.ts_pre, 1'b0, s_reg.fifo, s_reg.loop,
                        s_reg.sleep, s_reg.rst_req};
               end
               `CMT_OFS_STAT: begin
                  rd[3:0]             = s_reg.last_slot;
                  rd[`CMT_ST_TXSUCC]  = s_reg.tx_succ;
                  rd[`CMT_ST_RXSUCC]  = s_reg.rx_succ;
                  rd[`CMT_ST_TXSTATE] = (s_reg.opst == OPS_TX);
                  rd[`CMT_ST_RXSTATE] = (s_reg.opst == OPS_RX);
                  rd[`CMT_ST_RESET]   = !op;
                  rd[`CMT_ST_LOOP]    = s_reg.loop;
                  rd[`CMT_ST_FIFO]    = s_reg.fifo;
                  rd[`CMT_ST_PASSIVE] = (s_reg.tec >= `CMT_ERR_PASSIVE)
                                        || ({1'b0, s_reg.rec} >= `CMT_ERR_PASSIVE);
                  rd[`CMT_ST_BUSOFF]  = s_reg.busoff;
               end
               `CMT_OFS_BCFG: rd = {14'h0000, s_reg.bcfg};
               `CMT_OFS_CSEL: rd = {29'h0000_0000, s_reg.csel};
               `CMT_OFS_IEN:  rd = {16'h0000, s_reg.ien};
               `CMT_OFS_IDF:  rd = {16'h0000, s_reg.idf};
               `CMT_OFS_REC:  rd = {24'h00_0000, s_reg.rec};
               `CMT_OFS_TEC:  rd = {23'h00_0000, s_reg.tec};
               `CMT_OFS_TSR:  rd = {16'h0000, s_reg.ts};
               `CMT_OFS_GMR:  rd = {3'h0, s_reg.gmr};
               `CMT_OFS_LMA:  rd = {3'h0, s_reg.lma};
               `CMT_OFS_LMB:  rd = {3'h0, s_reg.lmb};
               `CMT_OFS_AFS:  rd = {5'h00, s_reg.afs, onehot, s_reg.afs[10:3]};
               default: begin
                  s_next.pslverr = 1'b1;
               end
            endcase
         end
         s_next.prdata = rd;
      end

      // Register write in the access phase
      if (wr && (i_apb.paddr[1:0] == 2'h0)) begin
         if (i_apb.paddr[7:6] == `CMT_REGION_SCTL) begin
            if (op) begin
               s_next.sctl[idx] = wd[7:0];
               s_next.sctl[idx][`CMT_SC_NEWDATA] = s_reg.sctl[idx][`CMT_SC_NEWDATA]
                                                   & wd[`CMT_SC_NEWDATA];
               s_next.sctl[idx][`CMT_SC_MSGLOST] = s_reg.sctl[idx][`CMT_SC_MSGLOST]
                                                   & wd[`CMT_SC_MSGLOST];
            end
         end else if (i_apb.paddr[7:6] == `CMT_REGION_SID) begin
            s_next.sid[idx] = wd[28:0];
         end else begin
            case (i_apb.paddr)
               `CMT_OFS_CTRL: begin
                  s_next.rst_req = wd[`CMT_CTL_RESET];
                  s_next.sleep   = wd[`CMT_CTL_SLEEP];
                  s_next.loop    = wd[`CMT_CTL_LOOP];
                  s_next.fifo    = wd[`CMT_CTL_FIFO];
                  s_next.ts_pre  = wd[`CMT_CTL_TSPRE +: 2];
               end
               `CMT_OFS_BCFG: s_next.bcfg = wd[17:0];
               `CMT_OFS_CSEL: s_next.csel = wd[2:0];
               `CMT_OFS_IEN: begin
                  if (op) begin
                     s_next.ien = wd[15:0];
                  end
               end
               `CMT_OFS_IDF: begin
                  if (op) begin
                     s_next.idf = wd[15:0];
                  end
               end
               `CMT_OFS_GMR:  s_next.gmr = wd[28:0];
               `CMT_OFS_LMA:  s_next.lma = wd[28:0];
               `CMT_OFS_LMB:  s_next.lmb = wd[28:0];
               default: begin
               end
            endcase
         end
      end

      // Quantum prescaler: 2 x clock divider x (field + 1)
      dsel    = (s_reg.csel > `CMT_CSEL_MAX) ? `CMT_CSEL_MAX : s_reg.csel;
      psc_lim = 10'((10'h002 << dsel) * ({6'h00, s_reg.bcfg[`CMT_BC_BRP +: 4]} + 10'h001)
                    - 10'h001);
      tq_now  = op && (s_reg.psc >= psc_lim);
      s_next.psc = tq_now ? 10'h000 : (s_reg.psc + 10'h001);
      s_next.tq  = tq_now;

      // Bit segments and resynchronisation
      prop_len = {1'b0, s_reg.bcfg[`CMT_BC_PROP +: 3]} + 4'h1;
      ps1_len  = {1'b0, s_reg.bcfg[`CMT_BC_PS1 +: 3]} + 4'h1 + s_reg.ps1_ext;
      ps2_len  = {1'b0, s_reg.bcfg[`CMT_BC_PS2 +: 3]} + 4'h1;
      resync_jump_width      = {2'h0, s_reg.bcfg[`CMT_BC_SJW +: 2]} + 4'h1;
      fall     = s_reg.rx_prev && !s_reg.rx_s2;
      perr     = (s_reg.seg == SEG_PROP) ? (s_reg.seg_cnt + 4'h1)
                                          : (prop_len + s_reg.seg_cnt + 4'h1);
      s_next.edge_pend = fall && tq_now;
      if (tq_now) begin
         case (s_reg.seg)
            SEG_SYNC: begin
               s_next.seg     = SEG_PROP;
               s_next.seg_cnt = 4'h0;
            end
            SEG_PROP: begin
               s_next.seg_cnt = s_reg.seg_cnt + 4'h1;
               if (s_reg.seg_cnt >= prop_len - 4'h1) begin
                  s_next.seg     = SEG_PS1;
                  s_next.seg_cnt = 4'h0;
               end
            end
            SEG_PS1: begin
               s_next.seg_cnt = s_reg.seg_cnt + 4'h1;
               if (s_reg.seg_cnt >= ps1_len - 4'h1) begin
                  s_next.seg     = SEG_PS2;
                  s_next.seg_cnt = 4'h0;
                  s_next.ps1_ext = 4'h0;
                  s_next.sample  = 1'b1;
               end
            end
            SEG_PS2: begin
               s_next.seg_cnt = s_reg.seg_cnt + 4'h1;
               if (s_reg.seg_cnt >= ps2_len - 4'h1) begin
                  s_next.seg      = SEG_SYNC;
                  s_next.seg_cnt  = 4'h0;
                  s_next.bit_tick = 1'b1;
               end
            end
            default: begin
               s_next.seg = SEG_SYNC;
            end
         endcase
      end else if (op && (fall || s_reg.edge_pend)) begin
         if ((s_reg.seg == SEG_PROP) || (s_reg.seg == SEG_PS1)) begin
            s_next.ps1_ext = (perr > resync_jump_width) ? resync_jump_width : perr;
         end else if (s_reg.seg == SEG_PS2) begin
            if ((ps2_len - s_reg.seg_cnt) <= resync_jump_width) begin
               s_next.seg      = SEG_SYNC;
               s_next.seg_cnt  = 4'h0;
               s_next.bit_tick = 1'b1;
            end else begin
               s_next.seg_cnt = s_reg.seg_cnt + resync_jump_width;
            end
         end
      end

      // Time stamp counter, one tick per 1, 2, 4 or 8 bit times
      if (s_next.bit_tick) begin
         s_next.ts_div = s_reg.ts_div + 3'h1;
         if ((s_reg.ts_div & tsm) == tsm) begin
            s_next.ts = s_reg.ts + 16'h0001;
         end
      end

      // Acceptance and slot update
      if (op && !s_reg.busoff && i_rx_frame.valid && (!i_rx_frame.own || s_reg.loop)) begin
         if (!i_rx_frame.ext) begin
            s_next.afs = i_rx_frame.id[28:18];
         end
         for (int j = 13; j >= 0; j--) begin
            if (match[j]) begin
               hit  = 1'b1;
               slot = 4'(j);
            end
         end
         if (!hit && (match[14] || match[15])) begin
            hit = 1'b1;
            if (s_reg.fifo) begin
               slot             = s_reg.fifo_next ? 4'hF : 4'hE;
               s_next.fifo_next = !s_reg.fifo_next;
            end else begin
               slot = match[14] ? 4'hE : 4'hF;
            end
         end
         if (hit) begin
            s_next.acc.valid = 1'b1;
            s_next.acc.slot  = slot;
            s_next.rx_succ   = 1'b1;
            s_next.last_slot = slot;
            s_next.sctl[slot][`CMT_SC_NEWDATA] = 1'b1;
            if (s_reg.sctl[slot][`CMT_SC_NEWDATA]) begin
               s_next.sctl[slot][`CMT_SC_MSGLOST] = 1'b1;
            end
         end
      end

      // Fault confinement counters
      if (op && !s_reg.busoff) begin
         if (i_err_evt.tx_err) begin
            s_next.tec = s_reg.tec + `CMT_TEC_INC;
         end else if (i_err_evt.tx_ok && (s_reg.tec != 9'h000)) begin
            s_next.tec = s_reg.tec - 9'h001;
         end
         if (i_err_evt.rx_err && (s_reg.rec != 8'hFF)) begin
            s_next.rec = s_reg.rec + 8'h01;
         end else if (i_err_evt.rx_ok && (s_reg.rec != 8'h00)) begin
            s_next.rec = s_reg.rec - 8'h01;
         end
         if (s_reg.tec >= `CMT_ERR_BUSOFF) begin
            s_next.busoff = 1'b1;
         end
         if (i_err_evt.tx_ok) begin
            s_next.tx_succ   = 1'b1;
            s_next.last_slot = i_err_evt.tx_slot;
         end
      end
      if (wr && (i_apb.paddr == `CMT_OFS_CTRL) && wd[`CMT_CTL_RETBO] && s_reg.busoff) begin
         s_next.busoff = 1'b0;
         s_next.tec    = 9'h000;
         s_next.rec    = 8'h00;
         s_next.reinit = 1'b1;
      end

      // Locked registers held at reset values outside operation
      if (!op) begin
         s_next.sctl      = '0;
         s_next.ien       = 16'h0000;
         s_next.idf       = 16'h0000;
         s_next.rec       = 8'h00;
         s_next.tec       = 9'h000;
         s_next.busoff    = 1'b0;
         s_next.ts        = 16'h0000;
         s_next.ts_div    = 3'h0;
         s_next.rx_succ   = 1'b0;
         s_next.tx_succ   = 1'b0;
         s_next.last_slot = 4'h0;
         s_next.fifo_next = 1'b0;
         s_next.seg       = SEG_SYNC;
         s_next.seg_cnt   = 4'h0;
         s_next.ps1_ext   = 4'h0;
      end

      if (i_sys_rst) begin
         s_next         = '0;
         s_next.mode    = MODE_RESET;
         s_next.rst_req = 1'b1;
         s_next.bcfg    = `CMT_BCFG_RST;
      end
   end

   always_ff @(posedge i_clk) begin
      s_reg <= s_next;
   end

   assign o_prdata        = s_reg.prdata;
   assign o_pready        = 1'b1;
   assign o_pslverr       = s_reg.pslverr;
   assign o_accept        = s_reg.acc;
   assign o_clk_gate_en   = (s_reg.mode != MODE_SLEEP);
   assign o_tx_enable     = (s_reg.mode == MODE_OP) && !s_reg.busoff;
   assign o_loopback      = s_reg.loop;
   assign o_engine_reinit = s_reg.reinit;
   assign o_tq_tick       = s_reg.tq;
   assign o_sample_point  = s_reg.sample;
   assign o_bit_tick      = s_reg.bit_tick;
   assign o_slot_irq_en   = s_reg.ien;
endmodule : cmt_ctrl
`default_nettype wire

/* File: dv/cmt_checker.sv */
// Assertions on the ports of the CAN mode and timing block
`timescale 1ns/10ps
`default_nettype none
module cmt_checker (
   input wire logic                   i_clk,
   input wire logic                   i_sys_rst,
   input wire cmt_pkg::cmt_apb_req_t  i_apb,
   input wire cmt_pkg::cmt_rx_frame_t i_rx_frame,
   input wire cmt_pkg::cmt_accept_t   o_accept,
   input wire logic                   o_clk_gate_en,
   input wire logic                   o_tx_enable,
   input wire logic                   o_loopback,
   input wire logic                   o_engine_reinit,
   input wire logic                   o_tq_tick,
   input wire logic                   o_sample_point,
   input wire logic                   o_bit_tick,
   input wire logic [15:0]            o_slot_irq_en
);
   logic ctl_wr;
   assign ctl_wr = i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.paddr == 8'h00;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // ****
   // Port properties
   // ****
   sequence s_ctl_wr;
      ctl_wr;
   endsequence
   a_reset_idle: assert property ($past(i_sys_rst) |-> !o_tx_enable && o_clk_gate_en)
      else $error("outputs not idle after reset");
   a_reset_irq: assert property ($past(i_sys_rst) |-> o_slot_irq_en == 16'h0)
      else $error("irq enables not cleared");
   a_accept_cause: assert property (o_accept.valid |-> $past(i_rx_frame.valid && o_tx_enable))
      else $error("accept without frame in operation");
   a_reinit_cause: assert property (o_engine_reinit |-> $past(ctl_wr && i_apb.pwdata[4])
      || $past(ctl_wr && i_apb.pwdata[4], 2))
      else $error("reinit without return write");
   a_reinit_single: assert property (o_engine_reinit |=> !o_engine_reinit)
      else $error("reinit longer than one cycle");
   a_tq_spacing: assert property (o_tq_tick |=> !o_tq_tick)
      else $error("quantum shorter than two clocks");
   a_sync_gap: assert property (o_bit_tick |=> !o_sample_point [*4])
      else $error("sample point too close to bit start");
   a_sleep_quiet: assert property (!o_clk_gate_en |-> !o_tq_tick && !o_tx_enable)
      else $error("activity while clock gated");
   a_loop_follow: assert property (s_ctl_wr |-> ##2 o_loopback == $past(i_apb.pwdata[2], 2))
      else $error("loopback not following control");
endmodule : cmt_checker
bind cmt_ctrl cmt_checker u_chk (.i_clk, .i_sys_rst, .i_apb, .i_rx_frame, .o_accept,
   .o_clk_gate_en, .o_tx_enable, .o_loopback, .o_engine_reinit, .o_tq_tick, .o_sample_point,
   .o_bit_tick, .o_slot_irq_en);
`default_nettype wire

/* File: dv/cmt_bus_model.sv */
// Behavioural protocol engine with the other nodes of the bus
`timescale 1ns/10ps
`default_nettype none
module cmt_bus_model (
   input  wire logic             i_clk,
   output logic                  o_can_rx,
   output logic                  o_tx_busy,
   output logic                  o_rx_busy,
   output cmt_pkg::cmt_rx_frame_t o_rx_frame,
   output cmt_pkg::cmt_err_evt_t  o_err_evt
);
   import cmt_pkg::*;
   // ****
   // Bus traffic
   // ****
   initial begin
      o_can_rx = 1'b1;
      o_tx_busy = 1'b0;
      o_rx_busy = 1'b0;
      o_rx_frame = '0;
      o_err_evt = '0;
   end
   // Another node sends; the line returns to recessive after the frame
   task automatic frame(input logic [28:0] id);
      o_rx_busy <= 1'b1;
      repeat (40) begin
         @(posedge i_clk);
         o_can_rx <= 1'($urandom);
      end
      o_can_rx <= 1'b1;
      o_rx_busy <= 1'b0;
      o_rx_frame <= '{1'b1, 1'b0, 1'b0, id};
      @(posedge i_clk);
      o_rx_frame.valid <= 1'b0;
   endtask : frame
   task automatic err(input int n, input logic is_tx);
      repeat (n) begin
         @(posedge i_clk);
         o_err_evt <= '{is_tx, !is_tx, 1'b0, 1'b0, 4'h0};
         @(posedge i_clk);
         o_err_evt <= '0;
      end
   endtask : err
   task automatic tx(input logic b);
      @(posedge i_clk);
      o_tx_busy <= b;
   endtask : tx
endmodule : cmt_bus_model
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the CAN mode and timing block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("BAD %0t %h %h", $time, (a), (e)); end end
module tb;
   import cmt_pkg::*;
   logic          i_clk = 1'b0;
   logic          i_sys_rst = 1'b1;
   cmt_apb_req_t  apb_q = '0;
   logic [31:0]   o_prdata, rdata, v;
   logic          o_pready, o_pslverr, perr, can_rx, tx_busy, rx_busy, o_clk_gate_en;
   logic          o_tx_enable, o_loopback, o_engine_reinit, o_tq_tick, o_sample_point, o_bit_tick;
   logic [15:0]   o_slot_irq_en;
   logic [3:0]    sl [4] = '{4'h3, 4'h5, 4'hE, 4'hF};
   cmt_rx_frame_t rx_frame;
   cmt_err_evt_t  err_evt;
   cmt_accept_t   o_accept;
   int            bad_count = 0;
   int            checks = 0;
   int            cyc = 0;
   cmt_ctrl dut (.i_clk, .i_sys_rst, .i_apb(apb_q), .o_prdata, .o_pready, .o_pslverr,
      .i_can_rx(can_rx), .i_tx_busy(tx_busy), .i_rx_busy(rx_busy), .i_rx_frame(rx_frame),
      .i_err_evt(err_evt), .o_accept, .o_clk_gate_en, .o_tx_enable, .o_loopback,
      .o_engine_reinit, .o_tq_tick, .o_sample_point, .o_bit_tick, .o_slot_irq_en);
   cmt_bus_model bm (.i_clk, .o_can_rx(can_rx), .o_tx_busy(tx_busy), .o_rx_busy(rx_busy),
      .o_rx_frame(rx_frame), .o_err_evt(err_evt));
   initial forever #2.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         final_report();
      end
   end
   // ****
   // Bus cycles and expectations
   // ****
   task automatic final_report();
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      apb_q <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_clk);
      apb_q.penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      rdata = o_prdata;
      perr = o_pslverr;
      apb_q <= '0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdata, e)
   endtask : rd
   task automatic tick(input logic b);
      do @(posedge i_clk); while ((b ? o_bit_tick : o_tq_tick) !== 1'b1);
   endtask : tick
   task automatic per(input logic b, input logic [31:0] e);
      logic [31:0] n = 0;
      tick(b);
      do begin
         @(posedge i_clk);
         n++;
      end while ((b ? o_bit_tick : o_tq_tick) !== 1'b1);
      `CHK(n, e)
   endtask : per
   task automatic rx(input logic [28:0] id, input logic [3:0] s);
      int n = 0;
      bm.frame(id);
      while (o_accept.valid !== 1'b1 && n < 9) begin
         @(posedge i_clk);
         n++;
      end
      `CHK({o_accept.valid, o_accept.slot}, {1'b1, s})
   endtask : rx
   function automatic logic [31:0] qn(logic [31:0] c, int s);
      return (32'h2 << s) * (c[3:0] + 32'h1);
   endfunction : qn
   function automatic logic [31:0] bq(logic [31:0] c);
      return 32'h4 + c[6:4] + c[10:8] + c[14:12];
   endfunction : bq
   initial begin
      void'($urandom(32'h68b3_faa1));
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(8'h00, 32'h1);
      rd(8'h04, 32'h100);
      rd(8'h08, 32'h2220);
      rd(8'h3C, 32'h0);
      `CHK(perr, 1'b1)
      apb(1'b1, 8'h10, $urandom | 32'h1);
      rd(8'h10, 32'h0);
      apb(1'b1, 8'h00, 32'h3);
      repeat (2) @(posedge i_clk);
      `CHK(o_clk_gate_en, 1'b0)
      apb(1'b1, 8'h00, 32'h1);
      for (int s = 0; s < 5; s++) begin
         v = ($urandom & 32'h3_7770) | (s == 0 ? 32'hF : $urandom % (16 >> s));
         apb(1'b1, 8'h0C, s);
         apb(1'b1, 8'h08, v);
         rd(8'h08, v);
         apb(1'b1, 8'h00, 32'h0);
         per(1'b0, qn(v, s));
         per(1'b1, qn(v, s) * bq(v));
         apb(1'b1, 8'h00, 32'h1);
      end
      apb(1'b1, 8'h00, 32'h9);
      apb(1'b1, 8'h00, 32'h8);
      rd(8'h04, 32'h800);
      apb(1'b1, 8'h24, 32'h1FFF_FFFF);
      foreach (sl[i]) begin
         apb(1'b1, {2'h2, sl[i], 2'h0}, 32'h048C_0000);
         apb(1'b1, {2'h1, sl[i], 2'h0}, 32'h40);
      end
      rx({11'h123, 18'h0}, 4'h3);
      rx({11'h123, 18'($urandom)}, 4'h3);
      rd(8'h4C, 32'h51);
      for (int k = 0; k < 3; k++)
         rx({11'h456, 18'h0}, 4'hE + 4'(k % 2));
      rd(8'h78, 32'h51);
      rd(8'h30, 32'h0456_408A);
      bm.err(3, 1'b0);
      rd(8'h18, 32'h3);
      bm.err(32, 1'b1);
      rd(8'h1C, 32'h100);
      `CHK({rdata[8], o_tx_enable}, 2'b10)
      rd(8'h04, 32'h682E);
      apb(1'b1, 8'h00, 32'h18);
      rd(8'h1C, 32'h0);
      rd(8'h18, 32'h0);
      rd(8'h8C, 32'h048C_0000);
      `CHK(o_tx_enable, 1'b1)
      for (int p = 0; p < 3; p++) begin
         apb(1'b1, 8'h00, 32'hC | (p << 5));
         tick(1'b1);
         apb(1'b0, 8'h20, 32'h0);
         v = rdata;
         repeat (4) tick(1'b1);
         apb(1'b0, 8'h20, 32'h0);
         `CHK(rdata - v, 32'h4 >> p)
      end
      bm.tx(1'b1);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      `CHK({rdata[8], rdata[6], o_tx_enable}, 3'b011)
      bm.tx(1'b0);
      apb(1'b0, 8'h04, 32'h0);
      `CHK({rdata[8], o_tx_enable}, 2'b10)
      final_report();
   end
endmodule : tb
`default_nettype wire
